// *** sacif_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacif_checker (
    // Clock and reset
    input wire logic                  core_clk, rst, clk_en,
    // Pins and front end
    input wire logic                  chip_sel_n_in, power_down_in, serial_data_oe_n,
    input wire logic                  conversion_active_out, conversion_active_oe_n,
    input wire logic [2:0]            mux_channel,
    input wire logic                  mux_differential, powered_down, sample_hold, compare_strobe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || !clk_en);
    // Four samples cover the two-flop pin synchroniser
    property p_stat_off; chip_sel_n_in [*4] |-> conversion_active_oe_n; endproperty
    a_stat_off: assert property (p_stat_off)
        else $error("status driven while deselected");
    property p_pd; power_down_in [*4] |-> powered_down; endproperty
    a_pd: assert property (p_pd)
        else $error("power down not followed");
    property p_str_pulse; compare_strobe |=> !compare_strobe; endproperty
    a_str_pulse: assert property (p_str_pulse)
        else $error("compare strobe longer than one cycle");
    property p_str_busy; compare_strobe |-> conversion_active_out; endproperty
    a_str_busy: assert property (p_str_busy)
        else $error("status low during conversion");
    property p_hold_busy; sample_hold && !conversion_active_oe_n |-> conversion_active_out; endproperty
    a_hold_busy: assert property (p_hold_busy)
        else $error("status low during acquisition");
    property p_out_sel; !serial_data_oe_n |-> !conversion_active_oe_n && !conversion_active_out; endproperty
    a_out_sel: assert property (p_out_sel)
        else $error("data driven while busy or deselected");
    property p_addr_hold; chip_sel_n_in [*4] |=> $stable({mux_differential, mux_channel}); endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address changed while deselected");
    property p_conv_gate; chip_sel_n_in [*4] |=> !compare_strobe; endproperty
    a_conv_gate: assert property (p_conv_gate)
        else $error("conversion runs while deselected");
endmodule : sacif_checker
bind sacif_top sacif_checker u_sacif_checker (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .chip_sel_n_in(chip_sel_n_in), .power_down_in(power_down_in),
    .serial_data_oe_n(serial_data_oe_n), .conversion_active_out(conversion_active_out),
    .conversion_active_oe_n(conversion_active_oe_n), .mux_channel(mux_channel),
    .mux_differential(mux_differential), .powered_down(powered_down),
    .sample_hold(sample_hold), .compare_strobe(compare_strobe));
`default_nettype wire

// *** sacif_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacif_host_model (
    input wire logic core_clk, serial_data_out, serial_data_oe_n,
    output var logic sclk, cs_n, sai, pd
);
    initial begin
        {sclk, cs_n, sai, pd} = 4'h4;
    end
    // Four core cycles a phase, above the two the synchroniser needs
    task automatic half;
        repeat (4) @(posedge core_clk);
    endtask : half
    // host clock pacing, address MSB first
    task automatic frame(input logic [3:0] a, output logic [10:0] got);
        cs_n <= 1'b0;
        for (int i = 0; i < 19; i++) begin
            half;
            // After the address phase the input keeps toggling through acquisition and conversion
            sai <= (i < 4) ? a[3 - i] : ~sai;
            half;
            sclk <= 1'b1;
            half;
            sclk <= 1'b0;
        end
        for (int j = 0; j < 11; j++) begin
            half;
            got[j] = serial_data_oe_n ? 1'bx : serial_data_out;
            sclk <= 1'b1;
            half;
            sclk <= 1'b0;
        end
        half;
        cs_n <= 1'b1;
    endtask : frame
    task automatic idle_clocks;
        for (int k = 0; k < 8; k++) begin
            half;
            sai <= ~sai;
            sclk <= ~sclk;
        end
    endtask : idle_clocks
endmodule : sacif_host_model
`default_nettype wire

// *** sacif_pkg.sv ***
// Behaviour
// - The single serial clock times the conversion, the acquisition and the serial exchange.
// - Each rising serial clock edge of the address phase shifts the serial input bit into the address shift register.
// - Address bits are captured only while chip select is low.
// - Chip select low enables address loading, result shifting and clocked conversion; high stops them.
// - The loaded address selects the channel connected for the next conversion.
// - The address also sets single-ended or differential mode across up to eight inputs.
// - Falling serial clock edges shift the result out, least significant bit first, sign bit last.
// - The serial output stays undriven until a conversion is done and chip select is low.
// - Power-down high powers the converter down; low keeps it running.
// - The status output is undriven while chip select is high.
// - With chip select low the status output is high during acquisition and conversion and low otherwise.
package sacif_pkg;
    localparam int          ADDR_BITS      = 4;
    localparam int          RESULT_BITS    = 11;
    localparam int          CHANNELS       = 8;
    localparam int          CH_BITS        = 3;
    localparam int          MODE_BIT_POS   = 3;
    localparam int          CH_LSB_POS     = 0;
    localparam int          ACQ_CYCLES     = 4;
    localparam int          CONV_CYCLES    = 11;
    localparam int          CNT_BITS       = 5;
    localparam real         SCLK_MIN_KHZ   = 5.0;
    localparam real         SCLK_MAX_KHZ   = 3000.0;
    localparam logic [3:0]  ADDR_RESET     = 4'h0;
    // Pin idle levels: serial clock low, deselected, address low, powered up
    localparam logic [3:0]  PIN_IDLE       = 4'h4;

    typedef enum logic [1:0] {
        SACIF_IDLE = 2'b00,
        SACIF_ACQ  = 2'b01,
        SACIF_CONV = 2'b10,
        SACIF_OUT  = 2'b11
    } sacif_state_t;
endpackage : sacif_pkg

// *** sacif_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacif_sync #(
    parameter int               WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= RESET_VAL;
            sync_out   <= RESET_VAL;
        end else if (clk_en) begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule : sacif_sync
`default_nettype wire

// *** sacif_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sacif_top #(
    parameter int ADDR_W = sacif_pkg::ADDR_BITS,
    parameter int RES_W  = sacif_pkg::RESULT_BITS
) (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic                           clk_en,
    // Serial link pins
    input  wire logic                           serial_clk_in,
    input  wire logic                           chip_sel_n_in,
    input  wire logic                           serial_addr_in,
    input  wire logic                           power_down_in,
    output logic                                serial_data_out,
    output logic                                serial_data_oe_n,
    output logic                                conversion_active_out,
    output logic                                conversion_active_oe_n,
    // Analog front end control
    output logic [sacif_pkg::CH_BITS-1:0]       mux_channel,
    output logic                                mux_differential,
    output logic                                powered_down,
    output logic                                sample_hold,
    output logic                                compare_strobe,
    input  wire logic [RES_W-1:0]               result_bits
);
    import sacif_pkg::*;

    logic [3:0]        pins_sync;
    logic              sclk_s;
    logic              cs_n_s;
    logic              din_s;
    logic              pd_s;
    logic              sclk_d_reg;
    logic              rise;
    logic              fall;
    logic [ADDR_W-1:0] shift_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [CNT_BITS-1:0] cnt_reg;
    logic [RES_W-1:0]  out_reg;
    logic              done_reg;
    sacif_state_t      state_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pins cross into core_clk before any logic sees them
    // Reset to idle pin levels, so no false select or edge follows reset
    sacif_sync #(
        .WIDTH     (4),
        .RESET_VAL (PIN_IDLE)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({serial_clk_in, chip_sel_n_in, serial_addr_in, power_down_in}),
        .sync_out (pins_sync)
    );
    assign sclk_s = pins_sync[3];
    assign cs_n_s = pins_sync[2];
    assign din_s  = pins_sync[1];
    assign pd_s   = pins_sync[0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
        end else if (clk_en) begin
            sclk_d_reg <= sclk_s;
        end
    end
    assign rise = clk_en && !cs_n_s && sclk_s && !sclk_d_reg;
    assign fall = clk_en && !cs_n_s && !sclk_s && sclk_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address shift register; loaded word taken at acquisition start
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= '0;
        end else if (rise && state_reg == SACIF_IDLE) begin
            shift_reg <= {shift_reg[ADDR_W-2:0], din_s};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_reg <= ADDR_W'(ADDR_RESET);
        end else if (rise && state_reg == SACIF_IDLE && cnt_reg == CNT_BITS'(ADDR_W - 1)) begin
            addr_reg <= {shift_reg[ADDR_W-2:0], din_s};
        end
    end
    assign mux_channel      = addr_reg[CH_LSB_POS +: CH_BITS];
    assign mux_differential = addr_reg[MODE_BIT_POS];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: address, acquisition, conversion, result out
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= SACIF_IDLE;
            cnt_reg   <= '0;
            done_reg  <= 1'b0;
        end else if (clk_en) begin
            if (pd_s) begin
                state_reg <= SACIF_IDLE;
                cnt_reg   <= '0;
                done_reg  <= 1'b0;
            end else if (cs_n_s) begin
                // Deselect aborts a frame; a finished result stays readable
                if (state_reg != SACIF_OUT) begin
                    state_reg <= SACIF_IDLE;
                end
                cnt_reg <= '0;
            end else if (rise) begin
                unique case (state_reg)
                    SACIF_IDLE: begin
                        if (cnt_reg == CNT_BITS'(ADDR_W - 1)) begin
                            state_reg <= SACIF_ACQ;
                            cnt_reg   <= '0;
                            done_reg  <= 1'b0;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                    SACIF_ACQ: begin
                        if (cnt_reg == CNT_BITS'(ACQ_CYCLES - 1)) begin
                            state_reg <= SACIF_CONV;
                            cnt_reg   <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                    SACIF_CONV: begin
                        if (cnt_reg == CNT_BITS'(CONV_CYCLES - 1)) begin
                            state_reg <= SACIF_OUT;
                            cnt_reg   <= '0;
                            done_reg  <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                    SACIF_OUT: begin
                        if (cnt_reg == CNT_BITS'(RES_W - 1)) begin
                            state_reg <= SACIF_IDLE;
                            cnt_reg   <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result capture and shift out
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_reg <= '0;
        end else if (rise && state_reg == SACIF_CONV && cnt_reg == CNT_BITS'(CONV_CYCLES - 1)) begin
            out_reg <= result_bits;
        end else if (fall && state_reg == SACIF_OUT && done_reg) begin
            out_reg <= {1'b0, out_reg[RES_W-1:1]};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_data_out <= 1'b0;
        end else if (fall && state_reg == SACIF_OUT && done_reg) begin
            serial_data_out <= out_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; enables are active low
    // drive after conversion
    assign serial_data_oe_n = !(done_reg && !cs_n_s && state_reg == SACIF_OUT);
    assign conversion_active_oe_n = cs_n_s;
    assign conversion_active_out = !cs_n_s &&
                                   (state_reg == SACIF_ACQ || state_reg == SACIF_CONV);
    assign powered_down   = pd_s;
    assign sample_hold    = state_reg == SACIF_ACQ;
    // Analog step advances once per serial clock, so timing tracks the host
    assign compare_strobe = rise && state_reg == SACIF_CONV;
endmodule : sacif_top
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sacif_pkg::*;
    logic                 core_clk, rst, clk_en;
    logic [10:0]          result_bits, got;
    wire logic            sclk, csn, sai, pd, sdo, sdo_oe_n, ca, ca_oe_n, dif, pdn, sh, str;
    wire logic [2:0]      mch;
    int                   mismatches, comparisons;
    int                   n_str, n_sh, n_busy;
    // Host serial clock period in core cycles: three four-cycle phases
    localparam int        SCLK_PERIOD = 12;
    sacif_top u_sacif_top (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .serial_clk_in(sclk), .chip_sel_n_in(csn), .serial_addr_in(sai), .power_down_in(pd),
        .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n), .conversion_active_out(ca),
        .conversion_active_oe_n(ca_oe_n), .mux_channel(mch), .mux_differential(dif),
        .powered_down(pdn), .sample_hold(sh), .compare_strobe(str), .result_bits(result_bits));
    sacif_host_model u_sacif_host_model (.core_clk(core_clk), .serial_data_out(sdo),
        .serial_data_oe_n(sdo_oe_n), .sclk(sclk), .cs_n(csn), .sai(sai), .pd(pd));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Cycle counts of the front-end strobes and the driven busy status
    always @(posedge core_clk) begin
        if (str === 1'b1)
            n_str++;
        if (sh === 1'b1)
            n_sh++;
        if (ca === 1'b1 && ca_oe_n === 1'b0)
            n_busy++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_frames;
        int s_str;
        int s_sh;
        int s_busy;
        // Every channel in both modes, sign bit tied to the address
        for (int a = 0; a < 16; a++) begin
            @(posedge core_clk);
            result_bits <= {a[3:0], 7'h35};
            s_str  = n_str;
            s_sh   = n_sh;
            s_busy = n_busy;
            u_sacif_host_model.frame(a[3:0], got);
            check(16'(got), {5'h00, a[3:0], 7'h35});
            check({12'h000, dif, mch}, 16'(a));
            check(16'(n_str - s_str), 16'(CONV_CYCLES));
            check(16'(n_sh - s_sh), 16'(ACQ_CYCLES * SCLK_PERIOD));
            check(16'(n_busy - s_busy), 16'((ACQ_CYCLES + CONV_CYCLES) * SCLK_PERIOD));
        end
        $display("frames done");
    endtask : t_frames
    task automatic t_deselect;
        u_sacif_host_model.idle_clocks;
        check({12'h000, dif, mch}, 16'h000F);
        check(16'(ca_oe_n), 16'h0001);
        check(16'(sdo_oe_n), 16'h0001);
        $display("deselect done");
    endtask : t_deselect
    task automatic t_power;
        @(posedge core_clk);
        // Clock enable low holds even the synchroniser still
        clk_en <= 1'b0;
        u_sacif_host_model.pd <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(16'(pdn), 16'h0000);
        clk_en <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(16'(pdn), 16'h0001);
        u_sacif_host_model.pd <= 1'b0;
        repeat (5) @(posedge core_clk);
        check(16'(pdn), 16'h0000);
        $display("power done");
    endtask : t_power
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        result_bits = 11'h000;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(16'(sdo_oe_n), 16'h0001);
        t_frames;
        t_deselect;
        t_power;
        end_of_test;
    end
    // Watchdog well above the sixteen frames
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire
